// File: rtl/psl_pkg.sv
// Shared types and constants for the PHY strap default loader
package psl_pkg;

    // ****************************************************
    // Strap vector and derived defaults
    // ****************************************************
    // Soft-strap values, one bit each
    typedef struct packed {
        logic auto_mdix;          // Crossover auto enable
        logic manual_mdix;        // 0 = MDI, 1 = MDIX
        logic autoneg;            // Negotiation enable
        logic speed;              // 1 = 100 Mb/s
        logic duplex;             // 1 = full duplex
        logic full_duplex_pause_strap;
        logic forced_pause_strap;
    } psl_strap_t;

    // Register defaults computed from the straps
    typedef struct packed {
        logic       an_en;        // Negotiation enable bit
        logic       speed_lsb;    // Speed select low bit
        logic       duplex;       // Duplex mode bit
        logic       adv_10hd;     // 10BASE-T half advertised
        logic       adv_10fd;     // 10BASE-T full advertised
        logic       sym_pause;    // Symmetric pause advertised
        logic       asym_pause;   // Asymmetric pause advertised
        logic [2:0] mode;         // PHY mode field
        logic       xover_en;     // Crossover enable strap state
    } psl_dflt_t;

    // ****************************************************
    // Widths, reset values and timing
    // ****************************************************
    localparam int         PIN_W       = 8;       // Seven straps plus fibre pin
    localparam psl_strap_t STRAP_RESET = 7'h5E;   // Tie-off defaults
    localparam logic [2:0] SETTLE_CYC  = 3'h4;    // Sync depth before latching
    localparam logic [2:0] MODE_AN     = 3'h7;    // All capable, negotiating
    localparam logic [2:0] MODE_FX     = 3'h3;    // Fixed 100 full for fibre

    // ****************************************************
    // Register map (byte offsets) and field positions
    // ****************************************************
    localparam logic [4:0] OFF_REG_A   = 5'h00;   // reg_a basic control
    localparam logic [4:0] OFF_ADV     = 5'h04;   // negotiation_advertise_reg
    localparam logic [4:0] OFF_REG_B   = 5'h08;   // reg_b special modes
    localparam logic [4:0] OFF_SPECIAL = 5'h0C;   // phy_special_control_reg
    localparam logic [4:0] OFF_HWCFG   = 5'h10;   // hardware_configuration_reg
    localparam logic [4:0] OFF_EECMD   = 5'h14;   // eeprom_command_reg
    localparam int A_AN      = 12;                // reg_a fields
    localparam int A_SPEED   = 13;
    localparam int A_DUPLEX  = 8;
    localparam int ADV_10HD  = 5;                 // advertisement fields
    localparam int ADV_10FD  = 6;
    localparam int ADV_100HD = 7;
    localparam int ADV_100FD = 8;
    localparam int ADV_SYM   = 10;
    localparam int ADV_ASYM  = 11;
    localparam int B_MODE    = 5;                 // reg_b mode field low bit
    localparam int SP_SEL    = 15;                // crossover_control_select
    localparam int SP_AUTO   = 14;                // Manual auto enable
    localparam int SP_MDIX   = 13;                // Manual MDIX
    localparam int HW_XOVER  = 1;                 // crossover_enable_state
    localparam int HW_FX     = 0;                 // Fibre mode latched
    localparam int EE_RELOAD = 0;                 // Reload command
    localparam int EE_DRST   = 1;                 // Digital reset command
    localparam int EE_LOADED = 8;                 // Straps came from EEPROM
    localparam logic [1:0] ADV_100_RESET = 2'h3;  // 100 Mb/s abilities
    localparam logic [2:0] SPECIAL_RESET = 3'h0;  // Strap-driven crossover

endpackage

// File: rtl/psl_sync3.sv
// Three-stage synchroniser with agreement filter for strap pins
`timescale 1ns/1ns
`default_nettype none
module psl_sync3
    import psl_pkg::*;
(
    input  wire logic             clock,
    input  wire logic             rstn,
    input  wire logic             ce,
    input  wire logic [PIN_W-1:0] pin_in,
    output logic      [PIN_W-1:0] level
);
    // ****************************************************
    // Stages
    // ****************************************************
    logic [PIN_W-1:0] s1;   // Metastable stage, read only by s2
    logic [PIN_W-1:0] s2;   // Second stage
    logic [PIN_W-1:0] s3;   // Third stage

    // Per-bit agreement between the last two stages
    wire  [PIN_W-1:0] agree = ~(s2 ^ s3);

    // Shift chain and filtered level
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            s1    <= '0;
            s2    <= '0;
            s3    <= '0;
            level <= '0;
        end else if (ce) begin
            s1    <= pin_in;
            s2    <= s1;
            s3    <= s2;
            level <= (agree & s3) | (~agree & level);
        end
    end
endmodule
`default_nettype wire

// File: rtl/psl_defaults.sv
// Combinational strap to register-default mapping
`timescale 1ns/1ns
`default_nettype none
module psl_defaults
    import psl_pkg::*;
(
    input  wire psl_strap_t st,
    input  wire logic       fx,
    output psl_dflt_t       dflt
);
    // ****************************************************
    // Copper defaults
    // ****************************************************
    // Negotiation forces speed, duplex and 10HD, while 10FD still follows duplex; else speed and duplex pick
    wire an  = st.autoneg;
    wire hd  = an | ~st.speed;
    wire fd  = st.duplex & (an | ~st.speed);
    wire pz  = st.full_duplex_pause_strap & ~st.forced_pause_strap;
    wire [2:0] md = an ? MODE_AN : {1'b0, st.speed, st.duplex};

    // ****************************************************
    // Fibre override
    // ****************************************************
    // Fibre ignores every copper strap; fixed values only
    assign dflt.an_en      = ~fx & an;
    assign dflt.speed_lsb  = fx | an | st.speed;
    assign dflt.duplex     = fx | an | st.duplex;
    assign dflt.adv_10hd   = ~fx & hd;
    assign dflt.adv_10fd   = ~fx & fd;
    assign dflt.sym_pause  = ~fx & pz;
    assign dflt.asym_pause = ~fx & pz;
    assign dflt.mode       = fx ? MODE_FX : md;
    assign dflt.xover_en   = ~fx & st.auto_mdix;
endmodule
`default_nettype wire

// File: rtl/psl_loader.sv
// PHY strap latch, override and register-default loader with Avalon-MM slave
//
// Function
// R1: Crossover strap sets crossover state bit default
// R2: Strap select drives crossover from both straps
// R3: Auto off: manual strap picks MDI/MDIX
// R4: Negotiation strap loads negotiation enable default
// R5: Negotiation strap shapes speed, duplex, advertise, mode
// R6: Fibre mode ignores copper and pause straps
// R7: Speed strap shapes speed, advertise, mode defaults
// R8: Duplex strap shapes duplex, 10FD, mode defaults
// R9: Full-duplex pause strap shapes asymmetric pause
// R10: Forced pause strap shapes both pause bits
// R11: Latch pins at reset release; EEPROM overrides
// R12: Digital reset/reload restore pin-latched values; with an EEPROM present eff is kept
// R13: Defaults reapplied at reset; software writes afterwards
`timescale 1ns/1ns
`default_nettype none
module psl_loader
    import psl_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rstn,
    input  wire logic        ce,
    input  wire psl_strap_t  strap_pins,
    input  wire logic        fx_mode_pin,
    input  wire logic        ee_present,
    input  wire logic        ee_load_valid,
    input  wire psl_strap_t  ee_load_straps,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output logic             xover_auto,
    output logic             xover_mdix,
    output logic             straps_latched
);
    // ****************************************************
    // Pin synchroniser and strap state
    // ****************************************************
    logic [PIN_W-1:0] pin_level;   // Filtered pin levels
    logic [2:0]       settle;      // Cycles since reset release
    psl_strap_t       pin_latch;   // Values captured at release
    logic             fx_lat;      // Fibre mode captured at release
    psl_strap_t       eff;         // Straps currently in force
    logic             ee_loaded;   // Eff came from the EEPROM
    logic             apply_q;     // Reload registers next edge
    psl_dflt_t        dflt;        // Defaults from eff

    // Fibre pin rides in the top bit of the same synchroniser
    psl_sync3 u_sync (
        .clock  (clock),
        .rstn   (rstn),
        .ce     (ce),
        .pin_in ({fx_mode_pin, strap_pins}),
        .level  (pin_level)
    );

    // Defaults follow eff combinationally; fibre uses the latched pin
    psl_defaults u_dflt (
        .st   (eff),
        .fx   (fx_lat),
        .dflt (dflt)
    );

    // ****************************************************
    // Register storage
    // ****************************************************
    logic       an_en;       // negotiation_enable_bit
    logic       speed_lsb;   // speed_select_low_bit
    logic       duplex;      // duplex_mode_bit
    logic       adv_10hd;    // Advertisement bits
    logic       adv_10fd;
    logic [1:0] adv_100;
    logic       sym_pause;
    logic       asym_pause;
    logic [2:0] mode;        // reg_b mode field
    logic [2:0] special;     // {select, auto, mdix} manual controls
    logic       xover_state; // crossover_enable_state

    // ****************************************************
    // Bus decode
    // ****************************************************
    // A request is accepted on the edge where waitrequest is low
    wire req      = avs_read | avs_write;
    wire acc_wr   = avs_write & ~avs_waitrequest;
    wire wr_a     = acc_wr & (avs_address == OFF_REG_A);
    wire wr_adv   = acc_wr & (avs_address == OFF_ADV);
    wire wr_b     = acc_wr & (avs_address == OFF_REG_B);
    wire wr_sp    = acc_wr & (avs_address == OFF_SPECIAL);
    wire wr_ee    = acc_wr & (avs_address == OFF_EECMD);
    wire cmd_rel  = wr_ee & avs_writedata[EE_RELOAD];
    wire cmd_drst = wr_ee & avs_writedata[EE_DRST];
    wire [31:0] wd = avs_writedata;

    // Latch fires once, after the synchroniser has filled
    // The filtered level trails the pins by four edges; latching
    // any sooner would capture the reset zeros of the filter
    wire latch_p  = ~straps_latched & (settle == SETTLE_CYC);
    wire ee_p     = ee_load_valid & ee_present & straps_latched;
    wire restore  = (cmd_rel | cmd_drst) & straps_latched;

    // Read mux: one word per register, unmapped reads zero
    // Reads have no side effect, so a repeated read is harmless
    function automatic logic [31:0] rd_word(input logic [4:0] a);
        logic [31:0] w;
        w = '0;
        unique case (a)
            OFF_REG_A: begin
                w[A_AN]     = an_en;
                w[A_SPEED]  = speed_lsb;
                w[A_DUPLEX] = duplex;
            end
            OFF_ADV: begin
                w[ADV_10HD]               = adv_10hd;
                w[ADV_10FD]               = adv_10fd;
                w[ADV_100FD:ADV_100HD]    = adv_100;
                w[ADV_SYM]                = sym_pause;
                w[ADV_ASYM]               = asym_pause;
            end
            OFF_REG_B:   w[B_MODE+2:B_MODE]   = mode;
            OFF_SPECIAL: w[SP_SEL:SP_MDIX]    = special;
            OFF_HWCFG: begin
                w[HW_XOVER] = xover_state;
                w[HW_FX]    = fx_lat;
            end
            OFF_EECMD: begin
                w[6:0]       = eff;
                w[EE_LOADED] = ee_loaded;
            end
            default: w = '0;
        endcase
        return w;
    endfunction

    wire [31:0] next_readdata = rd_word(avs_address);

    // ****************************************************
    // Crossover selection
    // ****************************************************
    // Select low hands crossover to the straps, as after reset
    // R2 strap or register source
    wire sel_reg     = special[2];
    wire next_auto   = fx_lat ? 1'b0 : (sel_reg ? special[1] : eff.auto_mdix);
    // R3 manual MDIX only when auto is off
    wire next_mdix   = fx_lat ? 1'b0 :
                       (sel_reg ? (~special[1] & special[0])
                                : (~eff.auto_mdix & eff.manual_mdix));

    // ****************************************************
    // Avalon slave handshake
    // ****************************************************
    // One wait cycle per access; read data loaded as wait drops
    // Fixed latency keeps the slave free of a state machine;
    // a master must drop its request after the accepted edge,
    // else the next edge sees a fresh request and waits again
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= '0;
        end else if (ce) begin
            avs_waitrequest <= ~(req & avs_waitrequest);
            avs_readdata    <= next_readdata;
        end
    end

    // ****************************************************
    // Strap latch and override
    // ****************************************************
    // Settle counter after reset release
    // Stops once latched, so it never wraps into a second capture
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            settle <= '0;
        end else if (ce && !straps_latched) begin
            settle <= settle + 3'h1;
        end
    end

    // R11 capture pins once, EEPROM may replace
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            straps_latched <= 1'b0;
            pin_latch      <= STRAP_RESET;
            fx_lat         <= 1'b0;
        end else if (ce && latch_p) begin
            straps_latched <= 1'b1;
            pin_latch      <= psl_strap_t'(pin_level[6:0]);
            fx_lat         <= pin_level[PIN_W-1];
        end
    end

    // Straps in force; a fresh EEPROM load beats a restore
    // With an EEPROM attached a restore keeps eff; the PHY
    // registers still reload from it, as after any digital reset
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            eff       <= STRAP_RESET;
            ee_loaded <= 1'b0;
        end else if (ce) begin
            if (latch_p) begin
                eff <= psl_strap_t'(pin_level[6:0]);
            end else if (ee_p) begin
                eff       <= ee_load_straps;
                ee_loaded <= 1'b1;
            // R12 no pin resample, pin-latched copy returns
            end else if (restore && !ee_present) begin
                eff       <= pin_latch;
                ee_loaded <= 1'b0;
            end
        end
    end

    // Registers reload one edge after eff settles
    // Reading dflt a cycle late avoids loading from old straps
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            apply_q <= 1'b0;
        end else if (ce) begin
            apply_q <= latch_p | ee_p | restore;
        end
    end

    // ****************************************************
    // PHY registers
    // ****************************************************
    // R13 defaults win over a write in the same cycle
    // A write that collides with a reload is lost, as after reset
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            {an_en, speed_lsb, duplex} <= '0;
            {adv_10hd, adv_10fd}       <= '0;
            {sym_pause, asym_pause}    <= '0;
            adv_100                    <= ADV_100_RESET;
            mode                       <= '0;
            special                    <= SPECIAL_RESET;
            xover_state                <= 1'b0;
        end else if (ce) begin
            if (apply_q) begin
                // R4 R5 R7 R8 R9 R10 R6 reset values
                an_en       <= dflt.an_en;
                speed_lsb   <= dflt.speed_lsb;
                duplex      <= dflt.duplex;
                adv_10hd    <= dflt.adv_10hd;
                adv_10fd    <= dflt.adv_10fd;
                sym_pause   <= dflt.sym_pause;
                asym_pause  <= dflt.asym_pause;
                adv_100     <= ADV_100_RESET;
                mode        <= dflt.mode;
                special     <= SPECIAL_RESET;
                // R1 strap state bit
                xover_state <= dflt.xover_en;
            end else begin
                if (wr_a) begin
                    an_en     <= wd[A_AN];
                    speed_lsb <= wd[A_SPEED];
                    duplex    <= wd[A_DUPLEX];
                end
                if (wr_adv) begin
                    adv_10hd   <= wd[ADV_10HD];
                    adv_10fd   <= wd[ADV_10FD];
                    adv_100    <= wd[ADV_100FD:ADV_100HD];
                    sym_pause  <= wd[ADV_SYM];
                    asym_pause <= wd[ADV_ASYM];
                end
                if (wr_b) begin
                    mode <= wd[B_MODE+2:B_MODE];
                end
                if (wr_sp) begin
                    special <= wd[SP_SEL:SP_MDIX];
                end
            end
        end
    end

    // Crossover outputs, registered
    // Fibre forces both low whatever the straps or register say
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            xover_auto <= 1'b0;
            xover_mdix <= 1'b0;
        end else if (ce) begin
            xover_auto <= next_auto;
            xover_mdix <= next_mdix;
        end
    end

    // ****************************************************
    // Assertions
    // ****************************************************
    // Frozen clock enable suspends every check
    // Crossover checks wait for the latch: just after reset release
    // the outputs still hold reset zeros while eff is the tie-off
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn || !ce);

    sequence s_latch_apply;
        latch_p ##1 apply_q;
    endsequence

    AST_XOVER_STATE: assert property ( // R1
        apply_q |=> xover_state == ($past(eff.auto_mdix) & ~fx_lat))
        else $error("crossover state bit default wrong");
    AST_STRAP_AUTO: assert property ( // R2
        (straps_latched && !sel_reg && !fx_lat) |=> xover_auto == $past(eff.auto_mdix))
        else $error("strap crossover enable not followed");
    AST_MANUAL_MDIX: assert property ( // R3
        (straps_latched && !sel_reg && !fx_lat && !eff.auto_mdix)
            |=> xover_mdix == $past(eff.manual_mdix))
        else $error("manual MDI/MDIX not followed");
    AST_AN_DEFAULT: assert property ( // R4
        (apply_q && !fx_lat) |=> an_en == $past(eff.autoneg))
        else $error("negotiation enable default wrong");
    AST_AN_MODE: assert property ( // R5
        (apply_q && !fx_lat && eff.autoneg) |=> mode == MODE_AN && speed_lsb && adv_10hd)
        else $error("negotiation mode default wrong");
    AST_FX_FIXED: assert property ( // R6
        (apply_q && fx_lat) |=> mode == MODE_FX && !an_en && !sym_pause && !xover_state)
        else $error("fibre defaults not fixed");
    AST_SPEED: assert property ( // R7
        (apply_q && !fx_lat && !eff.autoneg) |=> speed_lsb == $past(eff.speed)
            && adv_10hd == !$past(eff.speed))
        else $error("speed strap defaults wrong");
    AST_DUPLEX: assert property ( // R8
        (apply_q && !fx_lat && !eff.autoneg) |=> duplex == $past(eff.duplex)
            && mode == {1'b0, $past(eff.speed), $past(eff.duplex)})
        else $error("duplex strap defaults wrong");
    AST_FD_PAUSE: assert property ( // R9
        (apply_q && !fx_lat && !eff.forced_pause_strap)
            |=> asym_pause == $past(eff.full_duplex_pause_strap))
        else $error("asymmetric pause default wrong");
    AST_FORCED_PAUSE: assert property ( // R10
        (apply_q && eff.forced_pause_strap) |=> !sym_pause && !asym_pause)
        else $error("forced pause default wrong");
    AST_LATCH: assert property ( // R11
        s_latch_apply |-> straps_latched && eff == pin_latch)
        else $error("latch did not load straps");
    AST_RESTORE: assert property ( // R12
        (restore && !ee_p && !ee_present) |=> eff == pin_latch && apply_q)
        else $error("restore did not return pin values");
    AST_SW_WRITE: assert property ( // R13
        (wr_b && !apply_q) |=> mode == $past(wd[B_MODE+2:B_MODE]))
        else $error("register write lost");
endmodule
`default_nettype wire

// File: bench/psl_loader_tb.sv
// Self-checking bench for the PHY strap default loader
`timescale 1ns/1ns
`default_nettype none
module psl_loader_tb import psl_pkg::*;;
    // ************************************
    // Stimulus, observation and counters
    // ************************************
    typedef struct packed {
        logic [6:0] st;            // Strap pins
        logic       fx;            // Fibre pin
        logic [1:0] xo;            // Expected {auto, mdix}
    } psl_row_t;
    logic        clock, rstn, ce, fx_mode_pin, ee_present, ee_load_valid;
    logic        avs_read, avs_write, avs_waitrequest;
    logic        xover_auto, xover_mdix, straps_latched;
    psl_strap_t  strap_pins, ee_load_straps;
    logic [4:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    int          n_fail, compares, cyc;
    // Copper combinations, plus one fibre row
    psl_row_t    rows [8] = '{{7'h5E, 1'b0, 2'h2}, {7'h20, 1'b0, 2'h1}, {7'h04, 1'b0, 2'h0},
                              {7'h0A, 1'b0, 2'h0}, {7'h7F, 1'b0, 2'h2}, {7'h7F, 1'b1, 2'h0},
                              {7'h03, 1'b0, 2'h0}, {7'h10, 1'b0, 2'h0}};
    logic [4:0]  offs [4] = '{OFF_REG_A, OFF_ADV, OFF_REG_B, OFF_HWCFG};

    psl_loader i_dut (.clock(clock), .rstn(rstn), .ce(ce), .strap_pins(strap_pins),
        .fx_mode_pin(fx_mode_pin), .ee_present(ee_present), .ee_load_valid(ee_load_valid),
        .ee_load_straps(ee_load_straps), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .xover_auto(xover_auto), .xover_mdix(xover_mdix),
        .straps_latched(straps_latched));

    // Expected register word, worked out from the strap mapping
    function automatic logic [31:0] exp_reg(input logic [6:0] s, input logic fx,
                                            input logic [4:0] off);
        logic an, sp, dp, hd, fd, ps;
        logic [2:0] md;
        an = s[4]; sp = an | s[3]; dp = an | s[2];
        hd = an | ~s[3]; fd = s[2] & hd; ps = s[1] & ~s[0];
        md = an ? 3'h7 : {1'b0, s[3], s[2]};
        // Fibre ignores the copper and pause straps
        if (fx) begin
            an = 1'b0; sp = 1'b1; dp = 1'b1; hd = 1'b0; fd = 1'b0; ps = 1'b0; md = MODE_FX;
        end
        exp_reg = 32'h0;
        if (off == OFF_REG_A) begin
            exp_reg[A_AN] = an; exp_reg[A_SPEED] = sp; exp_reg[A_DUPLEX] = dp;
        end
        if (off == OFF_ADV) begin
            exp_reg[ADV_10HD] = hd; exp_reg[ADV_10FD] = fd; exp_reg[ADV_SYM] = ps;
            exp_reg[ADV_ASYM] = ps; exp_reg[ADV_100FD:ADV_100HD] = ADV_100_RESET;
        end
        if (off == OFF_REG_B) exp_reg[B_MODE+2:B_MODE] = md;
        if (off == OFF_HWCFG) begin
            exp_reg[HW_XOVER] = s[6] & ~fx; exp_reg[HW_FX] = fx;
        end
    endfunction

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One Avalon cycle; holds the request until waitrequest is seen low
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_address <= a; avs_writedata <= d; avs_read <= ~wr; avs_write <= wr;
        do begin
            @(posedge clock);
            n++;
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        chk("wait cycles", 32'h2, n);
        avs_read <= 1'b0; avs_write <= 1'b0;
        @(posedge clock);
    endtask

    // Pins held through the whole reset, so they are stable before release
    task automatic do_reset;
        rstn <= 1'b0;
        repeat (12) @(posedge clock);
        rstn <= 1'b1;
        repeat (8) @(posedge clock);
    endtask

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // Free-running clock, 10 ns period
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // Hang guard: the whole run needs well under this
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            complete_run();
        end
    end

    // ************************************
    // Main sequence
    // ************************************
    initial begin
        rstn = 1'b0; ce = 1'b1; strap_pins = STRAP_RESET; fx_mode_pin = 1'b0;
        ee_present = 1'b0; ee_load_valid = 1'b0; ee_load_straps = 7'h00;
        avs_address = 5'h00; avs_read = 1'b0; avs_write = 1'b0; avs_writedata = 32'h0;
        n_fail = 0; compares = 0; cyc = 0;
        repeat (3) @(posedge clock);
        chk("in reset", 32'h4, {29'h0, avs_waitrequest, xover_auto | xover_mdix, straps_latched});
        // Table of strap combinations, each after a fresh pin reset
        foreach (rows[i]) begin
            strap_pins <= rows[i].st;
            fx_mode_pin <= rows[i].fx;
            do_reset();
            chk("latched", 32'h1, {31'h0, straps_latched});
            chk("xover", {30'h0, rows[i].xo}, {30'h0, xover_auto, xover_mdix});
            foreach (offs[k]) begin
                bus(1'b0, offs[k], 32'h0);
                chk("reg", exp_reg(rows[i].st, rows[i].fx, offs[k]), rd);
            end
        end
        strap_pins <= STRAP_RESET;
        do_reset();
        // Software write, then reload restores default without pin resample
        bus(1'b1, OFF_REG_A, 32'h0);
        bus(1'b0, OFF_REG_A, 32'h0);
        chk("reg_a written", 32'h0, rd);
        bus(1'b1, OFF_REG_B, 32'hA0);
        bus(1'b0, OFF_REG_B, 32'h0);
        chk("reg_b written", 32'hA0, rd);
        strap_pins <= 7'h00;
        bus(1'b1, OFF_EECMD, 32'h1 << EE_RELOAD);
        bus(1'b0, OFF_EECMD, 32'h0);
        chk("eff after reload", 32'h5E, rd);
        bus(1'b0, OFF_REG_A, 32'h0);
        chk("reg_a reloaded", exp_reg(7'h5E, 1'b0, OFF_REG_A), rd);
        // EEPROM override, forced pause cancels full-duplex pause
        ee_present <= 1'b1; ee_load_straps <= 7'h23; ee_load_valid <= 1'b1;
        @(posedge clock);
        ee_load_valid <= 1'b0;
        repeat (2) @(posedge clock);
        chk("xover ee", 32'h1, {30'h0, xover_auto, xover_mdix});
        foreach (offs[k]) begin
            bus(1'b0, offs[k], 32'h0);
            chk("reg ee", exp_reg(7'h23, 1'b0, offs[k]), rd);
        end
        bus(1'b1, OFF_EECMD, 32'h1 << EE_DRST);
        bus(1'b0, OFF_EECMD, 32'h0);
        chk("eff kept", 32'h123, rd);
        // EEPROM gone: digital reset returns to pin-latched values
        ee_present <= 1'b0;
        bus(1'b1, OFF_EECMD, 32'h1 << EE_DRST);
        bus(1'b0, OFF_EECMD, 32'h0);
        chk("eff restored", 32'h5E, rd & 32'h7F);
        chk("xover restored", 32'h2, {30'h0, xover_auto, xover_mdix});
        // Frozen clock enable: an EEPROM load in that time is ignored
        ce <= 1'b0;
        ee_present <= 1'b1;
        ee_load_valid <= 1'b1;
        repeat (2) @(posedge clock);
        ce <= 1'b1;
        ee_load_valid <= 1'b0;
        ee_present <= 1'b0;
        bus(1'b0, OFF_EECMD, 32'h0);
        chk("ce frozen", 32'h5E, rd);
        // Register-driven crossover overrides the straps
        bus(1'b1, OFF_SPECIAL, 32'hA000);
        @(posedge clock);
        chk("xover reg", 32'h1, {30'h0, xover_auto, xover_mdix});
        // Unmapped and read-only places
        bus(1'b1, 5'h18, 32'hFFFF_FFFF);
        bus(1'b0, 5'h18, 32'h0);
        chk("unmapped", 32'h0, rd);
        bus(1'b1, OFF_HWCFG, 32'h0);
        bus(1'b0, OFF_HWCFG, 32'h0);
        chk("hwcfg ro", exp_reg(7'h5E, 1'b0, OFF_HWCFG), rd);
        complete_run();
    end
endmodule
`default_nettype wire
